// ### hw/fjl_decode_defs.vh
// constants for the fp / jump / load decode and check stage
// assumes a 32-bit instruction word with op in [31:30], op3 in [24:19], opf in [13:5]
`ifndef FJL_DECODE_DEFS_VH
`define FJL_DECODE_DEFS_VH

// instruction fields
`define FJL_OP_HI        31
`define FJL_OP_LO        30
`define FJL_RD_HI        29
`define FJL_RD_LO        25
`define FJL_OP2_HI       24
`define FJL_OP2_LO       22
`define FJL_OP3_HI       24
`define FJL_OP3_LO       19
`define FJL_RS1_HI       18
`define FJL_RS1_LO       14
`define FJL_I_BIT        13
`define FJL_OPF_HI       13
`define FJL_OPF_LO       5
`define FJL_ASI_HI       12
`define FJL_ASI_LO       5
`define FJL_SIMM_HI      12
`define FJL_SIMM_LO      0

// major opcodes
`define FJL_OP_BRANCH    2'h0
`define FJL_OP_ARITH     2'h2
`define FJL_OP_MEM       2'h3
`define FJL_OP2_FORCED   3'h0

// op3 values
`define FJL_OP3_FPOP1    6'h34
`define FJL_OP3_IMPL1    6'h36
`define FJL_OP3_WINCTL   6'h31
`define FJL_OP3_JUMP     6'h38
`define FJL_OP3_LD_UW    6'h00
`define FJL_OP3_LD_UB    6'h01
`define FJL_OP3_LD_UH    6'h02
`define FJL_OP3_LD_SW    6'h08
`define FJL_OP3_LD_SB    6'h09
`define FJL_OP3_LD_SH    6'h0a
`define FJL_OP3_LD_X     6'h0b

// opf value of the integer-to-quad conversion
`define FJL_OPF_XTOQ     9'h08c
// window-control function selecting mark-windows-invalid
`define FJL_FCN_MARKINV  5'h05

// fp trap type codes
`define FJL_FTT_NONE     3'h0
`define FJL_FTT_UNFIN    3'h2
`define FJL_FTT_UNIMP    3'h3

// execution-unit operation select
`define FJL_FU_NONE      3'h0
`define FJL_FU_SUB_S     3'h1
`define FJL_FU_SUB_D     3'h2
`define FJL_FU_XTO_S     3'h3
`define FJL_FU_XTO_D     3'h4

// load sizes
`define FJL_SZ_BYTE      2'h0
`define FJL_SZ_HALF      2'h1
`define FJL_SZ_WORD      2'h2
`define FJL_SZ_DWORD     2'h3

`define FJL_ADDR_W       64
`define FJL_AM_HI        63
`define FJL_AM_LO        32
`define FJL_UPPER_ZERO   32'h0000_0000
`define FJL_ZERO64       64'h0000_0000_0000_0000
`define FJL_RM_RESET     2'h0
`endif

// ### hw/fjl_decode.v
// decode and exception checks for fp subtract, int64 conversion, forced trap,
// implementation space, window invalidate, jump-and-link and integer loads.
// assumes operand values, pc and loaded memory data arrive on the core clock.
//
// Behaviour
// [RULE_01] subtract is rs1 minus rs2 into rd, rounded by the fp round mode
// [RULE_02] quad subtract is not executed and raises illegal instruction
// [RULE_03] fpu absent or either enable bit low gives fp disabled
// [RULE_04] enabled quad subtract reports fp other with unimplemented trap type
// [RULE_05] single and double subtract may report fp other as unfinished
// [RULE_06] int64 conversion reads signed 64-bit source, rounds by round mode
// [RULE_07] op3 11 0100 with opf 0 1000 1100 is the int-to-quad conversion
// [RULE_08] int64 conversion with nonzero bits 18 to 14 is illegal
// [RULE_09] int-to-quad is illegal, unimplemented fp other when fpu enabled
// [RULE_10] only int-to-single and int-to-double may signal inexact; the code also allows it for single and double subtract
// [RULE_11] forced trap opcode always illegal, constant field ignored
// [RULE_12] forced trap with nonzero bits 29 to 25 is illegal too
// [RULE_13] implementation space one leaves current and accrued fp exceptions
// [RULE_14] mark windows invalid opcode raises illegal for software emulation
// [RULE_15] jump target is rs1 plus rs2 or sign-extended immediate, delayed
// [RULE_16] jump-and-link writes its own pc into rd
// [RULE_17] jump with i zero and nonzero bits 12 to 5 is illegal
// [RULE_18] jump target with either low bit set is misaligned
// [RULE_19] address mask clears target upper 32 bits, memory and rd
// [RULE_20] loads right-justify, sign or zero extend; extended load fills all
// [RULE_21] loads misaligned per half, word and doubleword size; bytes never
// [RULE_22] load with i zero and nonzero bits 12 to 5 is illegal
// [RULE_23] quad opcodes report illegal ahead of fp disabled or fp other
`timescale 1ns/100ps
`include "fjl_decode_defs.vh"

module fjl_decode #(
    parameter [8:0] OPF_SUB_S  = 9'h045,
    parameter [8:0] OPF_SUB_D  = 9'h046,
    parameter [8:0] OPF_SUB_Q  = 9'h047,
    parameter [8:0] OPF_XTO_S  = 9'h084,
    parameter [8:0] OPF_XTO_D  = 9'h088
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        issue_valid,
    input  wire [31:0] insn,
    input  wire [63:0] pc,
    input  wire [63:0] rs1_value,
    input  wire [63:0] rs2_value,
    input  wire        fpu_present,
    input  wire        fp_state_enable_bit,
    input  wire        proc_state_fp_enable,
    input  wire        proc_state_addr_mask,
    input  wire [1:0]  fp_round_mode_field,
    input  wire        fp_unfinished,
    input  wire        mem_rvalid,
    input  wire [63:0] mem_rdata,
    output reg         done_valid,
    output reg         trap_illegal,
    output reg         trap_fp_disabled,
    output reg         trap_fp_other,
    output reg  [2:0]  fp_trap_type_field,
    output reg         trap_misaligned,
    output reg  [2:0]  fu_op,
    output reg  [1:0]  fu_round_mode,
    output reg         fu_inexact_allowed,
    output reg         fp_exc_hold,
    output reg         jump_taken,
    output reg  [63:0] jump_target,
    output reg         rd_write,
    output reg  [63:0] rd_value,
    output reg         load_req,
    output reg  [63:0] load_addr,
    output reg  [1:0]  load_size,
    output reg         load_signed,
    output reg         load_done,
    output reg  [63:0] load_result
);

////////////////////////////////////////////////////////////////////////////////
// field extraction

wire [1:0]  f_op   = insn[`FJL_OP_HI:`FJL_OP_LO];
wire [4:0]  f_rd   = insn[`FJL_RD_HI:`FJL_RD_LO];
wire [2:0]  f_op2  = insn[`FJL_OP2_HI:`FJL_OP2_LO];
wire [5:0]  f_op3  = insn[`FJL_OP3_HI:`FJL_OP3_LO];
wire [4:0]  f_rs1  = insn[`FJL_RS1_HI:`FJL_RS1_LO];
wire        f_i    = insn[`FJL_I_BIT];
wire [8:0]  f_opf  = insn[`FJL_OPF_HI:`FJL_OPF_LO];
wire [7:0]  f_asi  = insn[`FJL_ASI_HI:`FJL_ASI_LO];
wire [12:0] signed_immediate_field = insn[`FJL_SIMM_HI:`FJL_SIMM_LO];

wire fp_on = fpu_present & fp_state_enable_bit & proc_state_fp_enable; // RULE_03

wire is_fpop1 = issue_valid & (f_op == `FJL_OP_ARITH) & (f_op3 == `FJL_OP3_FPOP1);
wire fp_subtract_op      = is_fpop1 & ((f_opf == OPF_SUB_S) | (f_opf == OPF_SUB_D));
wire fp_subtract_quad_op = is_fpop1 & (f_opf == OPF_SUB_Q);
wire int64_to_quad_op    = is_fpop1 & (f_opf == `FJL_OPF_XTOQ); // RULE_07
wire int64_conv_op       = is_fpop1 & ((f_opf == OPF_XTO_S) | (f_opf == OPF_XTO_D));
wire conv_any            = int64_conv_op | int64_to_quad_op;
wire conv_bad_rs1        = conv_any & (f_rs1 != 5'h00); // RULE_08

// constant field deliberately not looked at
wire forced_illegal_trap_op = issue_valid & (f_op == `FJL_OP_BRANCH) & (f_op2 == `FJL_OP2_FORCED); // RULE_11
wire impl_dep_space_one = issue_valid & (f_op == `FJL_OP_ARITH) & (f_op3 == `FJL_OP3_IMPL1);
wire mark_windows_invalid_op = issue_valid & (f_op == `FJL_OP_ARITH) & (f_op3 == `FJL_OP3_WINCTL)
                             & (f_rd == `FJL_FCN_MARKINV);
wire jump_and_link_op   = issue_valid & (f_op == `FJL_OP_ARITH) & (f_op3 == `FJL_OP3_JUMP);
wire asi_nonzero        = (f_asi != 8'h00);

////////////////////////////////////////////////////////////////////////////////
// load opcode classification

reg       is_load;
reg [1:0] ld_sz;
reg       ld_sgn;

always @* begin
    is_load = issue_valid & (f_op == `FJL_OP_MEM);
    ld_sz   = `FJL_SZ_BYTE;
    ld_sgn  = 1'b0;
    case (f_op3)
        `FJL_OP3_LD_UB: ld_sz = `FJL_SZ_BYTE;
        `FJL_OP3_LD_UH: ld_sz = `FJL_SZ_HALF;
        `FJL_OP3_LD_UW: ld_sz = `FJL_SZ_WORD;
        `FJL_OP3_LD_SB: begin
            ld_sz  = `FJL_SZ_BYTE;
            ld_sgn = 1'b1;
        end
        `FJL_OP3_LD_SH: begin
            ld_sz  = `FJL_SZ_HALF;
            ld_sgn = 1'b1;
        end
        `FJL_OP3_LD_SW: begin
            ld_sz  = `FJL_SZ_WORD;
            ld_sgn = 1'b1;
        end
        `FJL_OP3_LD_X:  ld_sz = `FJL_SZ_DWORD;
        default:       is_load = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// address generation shared by jump and load

wire [63:0] simm_ext = {{51{signed_immediate_field[12]}}, signed_immediate_field};
wire [63:0] eff_raw  = rs1_value + (f_i ? simm_ext : rs2_value); // RULE_15
// address mask applies to the memory address, the jump target and the link pc alike
wire [63:0] eff_addr = proc_state_addr_mask ? {`FJL_UPPER_ZERO, eff_raw[31:0]} : eff_raw; // RULE_19
wire [63:0] link_pc  = proc_state_addr_mask ? {`FJL_UPPER_ZERO, pc[31:0]} : pc; // RULE_19

wire jmp_bad_bits = jump_and_link_op & ~f_i & asi_nonzero; // RULE_17
wire ld_bad_bits  = is_load & ~f_i & asi_nonzero; // RULE_22
wire jmp_misalign = jump_and_link_op & (eff_addr[1:0] != 2'h0); // RULE_18

reg ld_misalign;
always @* begin
    case (ld_sz)
        `FJL_SZ_HALF:  ld_misalign = eff_addr[0]; // RULE_21
        `FJL_SZ_WORD:  ld_misalign = (eff_addr[1:0] != 2'h0); // RULE_21
        `FJL_SZ_DWORD: ld_misalign = (eff_addr[2:0] != 3'h0); // RULE_21
        default:       ld_misalign = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// trap priority: illegal first so each instruction raises one trap

wire quad_op = fp_subtract_quad_op | int64_to_quad_op;

wire next_illegal = quad_op                        // RULE_02 RULE_09 RULE_23
                  | conv_bad_rs1
                  | forced_illegal_trap_op          // RULE_12
                  | mark_windows_invalid_op         // RULE_14
                  | jmp_bad_bits
                  | ld_bad_bits;

wire fp_family     = fp_subtract_op | int64_conv_op;
wire next_fp_dis   = ~next_illegal & fp_family & ~fp_on; // RULE_03
wire fp_live       = ~next_illegal & fp_family & fp_on;
wire sub_unfinish  = fp_live & fp_subtract_op & fp_unfinished; // RULE_05

// quad ops with the fpu enabled report the unimplemented type for software even though illegal traps
wire [2:0] next_ftt = (quad_op & fp_on) ? `FJL_FTT_UNIMP :       // RULE_04 RULE_09
                      sub_unfinish      ? `FJL_FTT_UNFIN : `FJL_FTT_NONE; // RULE_05

wire next_misalign = ~next_illegal & (jmp_misalign | (is_load & ld_misalign));

reg [2:0] next_fu_op;
always @* begin
    next_fu_op = `FJL_FU_NONE;
    if (fp_live & ~sub_unfinish) begin
        if (f_opf == OPF_SUB_S)
            next_fu_op = `FJL_FU_SUB_S; // RULE_01
        else if (f_opf == OPF_SUB_D)
            next_fu_op = `FJL_FU_SUB_D; // RULE_01
        else if (f_opf == OPF_XTO_S)
            next_fu_op = `FJL_FU_XTO_S; // RULE_06
        else if (f_opf == OPF_XTO_D)
            next_fu_op = `FJL_FU_XTO_D; // RULE_06
    end
end

////////////////////////////////////////////////////////////////////////////////
// load return alignment and extension; size held from the request

reg [63:0] next_load_result;
always @* begin
    case (load_size)
        `FJL_SZ_BYTE:  next_load_result = {{56{load_signed & mem_rdata[7]}}, mem_rdata[7:0]}; // RULE_20
        `FJL_SZ_HALF:  next_load_result = {{48{load_signed & mem_rdata[15]}}, mem_rdata[15:0]}; // RULE_20
        `FJL_SZ_WORD:  next_load_result = {{32{load_signed & mem_rdata[31]}}, mem_rdata[31:0]}; // RULE_20
        default:       next_load_result = mem_rdata; // RULE_20
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// trap outputs, one cycle after issue

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        done_valid         <= 1'b0;
        trap_illegal       <= 1'b0;
        trap_fp_disabled   <= 1'b0;
        trap_fp_other      <= 1'b0;
        fp_trap_type_field <= `FJL_FTT_NONE;
        trap_misaligned    <= 1'b0;
    end else begin
        done_valid         <= issue_valid;
        trap_illegal       <= next_illegal;
        trap_fp_disabled   <= next_fp_dis;
        // quad ops trap illegal instead, so only unfinished raises fp other
        trap_fp_other      <= sub_unfinish; // RULE_05 RULE_23
        fp_trap_type_field <= next_ftt;
        trap_misaligned    <= next_misalign;
    end
end

////////////////////////////////////////////////////////////////////////////////
// fp unit request

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        fu_op              <= `FJL_FU_NONE;
        fu_round_mode      <= `FJL_RM_RESET;
        fu_inexact_allowed <= 1'b0;
        fp_exc_hold        <= 1'b0;
    end else begin
        fu_op              <= next_fu_op;
        fu_round_mode      <= fp_round_mode_field; // RULE_01 RULE_06
        // subtract may round inexactly too; quad conversion never reaches the unit
        fu_inexact_allowed <= (next_fu_op == `FJL_FU_XTO_S) | (next_fu_op == `FJL_FU_XTO_D) // RULE_10
                            | (next_fu_op == `FJL_FU_SUB_S) | (next_fu_op == `FJL_FU_SUB_D);
        fp_exc_hold        <= impl_dep_space_one; // RULE_13
    end
end

////////////////////////////////////////////////////////////////////////////////
// jump and link: target and link value

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        jump_taken         <= 1'b0;
        jump_target        <= `FJL_ZERO64;
        rd_write           <= 1'b0;
        rd_value           <= `FJL_ZERO64;
    end else begin
        jump_taken         <= jump_and_link_op & ~next_illegal & ~jmp_misalign; // RULE_15
        jump_target        <= eff_addr; // RULE_19
        rd_write           <= jump_and_link_op & ~next_illegal & ~jmp_misalign; // RULE_16
        rd_value           <= link_pc; // RULE_16
    end
end

////////////////////////////////////////////////////////////////////////////////
// load request; address, size and sign hold until the next load

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        load_req           <= 1'b0;
        load_addr          <= `FJL_ZERO64;
        load_size          <= `FJL_SZ_BYTE;
        load_signed        <= 1'b0;
    end else begin
        load_req           <= is_load & ~next_illegal & ~ld_misalign; // RULE_21
        if (is_load) begin
            load_addr   <= eff_addr;
            load_size   <= ld_sz;
            load_signed <= ld_sgn;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// load return; result holds until the next return

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        load_done          <= 1'b0;
        load_result        <= `FJL_ZERO64;
    end else begin
        load_done          <= mem_rvalid;
        if (mem_rvalid)
            load_result <= next_load_result; // RULE_20
    end
end

endmodule // fjl_decode

// ### sim/fjl_decode_properties.sv
// concurrent checks on the fp / jump / load decode stage ports
// assumes one core clock and an asynchronous active-high reset
`timescale 1ns/100ps
module fjl_decode_properties (
    input wire        sys_clk,
    input wire        rst,
    input wire        issue_valid,
    input wire [31:0] insn,
    input wire [63:0] pc,
    input wire [63:0] rs1_value,
    input wire        fpu_present,
    input wire        fp_state_enable_bit,
    input wire        proc_state_fp_enable,
    input wire        proc_state_addr_mask,
    input wire        trap_illegal,
    input wire        trap_fp_disabled,
    input wire [2:0]  fp_trap_type_field,
    input wire        trap_misaligned,
    input wire        fp_exc_hold,
    input wire        jump_taken,
    input wire [63:0] jump_target,
    input wire [63:0] rd_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire        arith  = issue_valid && insn[31:30] == 2'h2;
    wire        fp_on  = fpu_present && fp_state_enable_bit && proc_state_fp_enable;
    wire [63:0] target = rs1_value + {{51{insn[12]}}, insn[12:0]};
    sequence s_fpop(opf);
        arith && insn[24:19] == 6'h34 && insn[13:5] == opf;
    endsequence
    sequence s_jump_imm;
        arith && insn[24:19] == 6'h38 && insn[13];
    endsequence
    a_quad_sub_illegal: assert property (
        s_fpop(9'h047) |=> trap_illegal && !trap_fp_disabled) else $error("quad subtract not illegal");
    a_sub_fp_disabled: assert property (
        s_fpop(9'h046) ##0 !fp_on |=> trap_fp_disabled && !trap_illegal) else $error("subtract not disabled");
    a_quad_conv_unimp: assert property (
        s_fpop(9'h08c) ##0 fp_on && insn[18:14] == 5'h00 |=> trap_illegal && fp_trap_type_field == 3'h3)
        else $error("int to quad not unimplemented");
    a_conv_src_field: assert property (
        (s_fpop(9'h084) or s_fpop(9'h088)) ##0 insn[18:14] != 5'h00 |=> trap_illegal) else $error("bad conversion");
    a_forced_trap: assert property (
        issue_valid && insn[31:30] == 2'h0 && insn[24:22] == 3'h0 |=> trap_illegal) else $error("forced trap missed");
    a_impl_space_hold: assert property (
        arith && insn[24:19] == 6'h36 |=> fp_exc_hold) else $error("fp exceptions not held");
    a_windows_invalid: assert property (
        arith && insn[24:19] == 6'h31 && insn[29:25] == 5'h05 |=> trap_illegal) else $error("window op not illegal");
    a_jump_reg_bits: assert property (
        arith && insn[24:19] == 6'h38 && !insn[13] && insn[12:5] != 8'h00 |=> trap_illegal && !jump_taken)
        else $error("jump spare bits not illegal");
    a_jump_link: assert property (
        s_jump_imm ##0 !proc_state_addr_mask && target[1:0] == 2'h0
        |=> jump_taken && jump_target == $past(target) && rd_value == $past(pc)) else $error("jump or link wrong");
    a_jump_misaligned: assert property (
        s_jump_imm ##0 target[1:0] != 2'h0 |=> trap_misaligned && !jump_taken) else $error("jump misalign missed");
    a_addr_mask: assert property (
        s_jump_imm ##0 proc_state_addr_mask |=> jump_target[63:32] == 32'h0 && rd_value[63:32] == 32'h0)
        else $error("address mask not applied");
endmodule // fjl_decode_properties
bind fjl_decode fjl_decode_properties u_fjl_decode_properties (
    .sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .insn(insn), .pc(pc), .rs1_value(rs1_value),
    .fpu_present(fpu_present), .fp_state_enable_bit(fp_state_enable_bit), .proc_state_fp_enable(proc_state_fp_enable),
    .proc_state_addr_mask(proc_state_addr_mask), .trap_illegal(trap_illegal), .trap_fp_disabled(trap_fp_disabled),
    .fp_trap_type_field(fp_trap_type_field), .trap_misaligned(trap_misaligned), .fp_exc_hold(fp_exc_hold),
    .jump_taken(jump_taken), .jump_target(jump_target), .rd_value(rd_value));

// ### sim/fjl_decode_tb.sv
// self-checking bench for the fp / jump / load decode stage
// assumes answers one cycle after issue; inputs change on falling edges
`timescale 1ns/100ps
module fjl_decode_tb;
    reg         sys_clk = 1'b0;
    reg         rst = 1'b1;
    reg         issue_valid = 1'b0;
    reg  [31:0] insn = 32'h0;
    reg  [63:0] pc = 64'h0, rs1_value = 64'h0, rs2_value = 64'h0, mem_rdata = 64'h0;
    reg         fpu_present = 1'b1, fp_state_enable_bit = 1'b1, proc_state_fp_enable = 1'b1;
    reg         proc_state_addr_mask = 1'b0, fp_unfinished = 1'b0, mem_rvalid = 1'b0;
    reg  [1:0]  fp_round_mode_field = 2'h0;
    wire        done_valid, trap_illegal, trap_fp_disabled, trap_fp_other, trap_misaligned, fu_inexact_allowed;
    wire        fp_exc_hold, jump_taken, rd_write, load_req, load_signed, load_done;
    wire [2:0]  fp_trap_type_field, fu_op;
    wire [1:0]  fu_round_mode, load_size;
    wire [63:0] jump_target, rd_value, load_addr, load_result;
    integer     err_count = 0;
    integer     comparisons = 0;
    always #2.5 sys_clk = ~sys_clk;
    fjl_decode u_fjl_decode (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .insn(insn), .pc(pc),
        .rs1_value(rs1_value), .rs2_value(rs2_value), .fpu_present(fpu_present),
        .fp_state_enable_bit(fp_state_enable_bit), .proc_state_fp_enable(proc_state_fp_enable),
        .proc_state_addr_mask(proc_state_addr_mask), .fp_round_mode_field(fp_round_mode_field),
        .fp_unfinished(fp_unfinished), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .done_valid(done_valid),
        .trap_illegal(trap_illegal), .trap_fp_disabled(trap_fp_disabled), .trap_fp_other(trap_fp_other),
        .fp_trap_type_field(fp_trap_type_field), .trap_misaligned(trap_misaligned), .fu_op(fu_op),
        .fu_round_mode(fu_round_mode), .fu_inexact_allowed(fu_inexact_allowed), .fp_exc_hold(fp_exc_hold),
        .jump_taken(jump_taken), .jump_target(jump_target), .rd_write(rd_write), .rd_value(rd_value),
        .load_req(load_req), .load_addr(load_addr), .load_size(load_size), .load_signed(load_signed),
        .load_done(load_done), .load_result(load_result));
    ////////////////////////////////////////////////////////////////
    task chk(input string what, input [63:0] seen, input [63:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    function [31:0] f3(input [1:0] op, input [4:0] rd, input [5:0] op3, input [4:0] r1, input [13:0] low);
        f3 = {op, rd, op3, r1, low};
    endfunction
    // one-cycle issue; outputs are judged in the answer cycle
    task issue(input [31:0] word, input [63:0] a, input [63:0] b);
        @(negedge sys_clk);
        insn = word;
        rs1_value = a;
        rs2_value = b;
        issue_valid = 1'b1;
        @(negedge sys_clk);
        issue_valid = 1'b0;
    endtask
    // e = illegal, disabled, fp other, trap type, misaligned
    task traps(input [6:0] e);
        chk("traps", {56'h0, done_valid, trap_illegal, trap_fp_disabled, trap_fp_other, fp_trap_type_field,
            trap_misaligned}, {56'h0, 1'b1, e});
    endtask
    task fu(input [5:0] e);
        chk("fu", {58'h0, fu_op, fu_round_mode, fu_inexact_allowed}, {58'h0, e});
    endtask
    task fpi(input [8:0] opf, input [4:0] r1, input [1:0] rm);
        fp_round_mode_field = rm;
        issue(f3(2'h2, 5'h2, 6'h34, r1, {opf, 5'h3}), 64'h0, 64'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_fp;
        integer k;
        for (k = 0; k < 3; k = k + 1) begin
            {fpu_present, fp_state_enable_bit, proc_state_fp_enable} = ~(3'h1 << k);
            fpi(9'h046, 5'h1, 2'h0);
            traps(7'h20);
            fpi(9'h084, 5'h0, 2'h0);
            traps(7'h20);
            fpi(9'h047, 5'h1, 2'h0);
            traps(7'h40);
        end
        {fpu_present, fp_state_enable_bit, proc_state_fp_enable} = 3'h7;
        fpi(9'h045, 5'h1, 2'h3);
        traps(7'h00);
        fu(6'h0f);
        fpi(9'h046, 5'h1, 2'h2);
        fu(6'h15);
        fpi(9'h084, 5'h0, 2'h1);
        traps(7'h00);
        fu(6'h1b);
        fpi(9'h088, 5'h0, 2'h0);
        fu(6'h21);
        fpi(9'h047, 5'h1, 2'h0);
        traps(7'h46);
        fpi(9'h08c, 5'h0, 2'h0);
        traps(7'h46);
        fu(6'h00);
        fpi(9'h088, 5'h10, 2'h0);
        traps(7'h40);
        fp_unfinished = 1'b1;
        fpi(9'h046, 5'h1, 2'h0);
        fp_unfinished = 1'b0;
        traps(7'h14);
    endtask
    task t_misc;
        issue({2'h0, 5'h1f, 3'h0, 22'h3f_ffff}, 64'h0, 64'h0);
        traps(7'h40);
        issue(32'h0, 64'h0, 64'h0);
        traps(7'h40);
        issue(f3(2'h2, 5'h0, 6'h36, 5'h1, 14'h0), 64'h0, 64'h0);
        chk("exc_hold", {63'h0, fp_exc_hold}, 64'h1);
        issue(f3(2'h2, 5'h05, 6'h31, 5'h0, 14'h0), 64'h0, 64'h0);
        traps(7'h40);
    endtask
    task t_jump;
        pc = 64'h1234_5678_9abc_def0;
        issue(f3(2'h2, 5'hf, 6'h38, 5'h1, {1'b1, 13'h1ff8}), 64'h1000, 64'h0);
        traps(7'h00);
        chk("target", {jump_target[62:0], jump_taken}, {63'hff8, 1'b1});
        chk("link", {rd_value[62:0], rd_write}, {pc[62:0], 1'b1});
        issue(f3(2'h2, 5'hf, 6'h38, 5'h1, {1'b0, 8'h00, 5'h2}), 64'h100, 64'h24);
        chk("target", {jump_target[62:0], jump_taken}, {63'h124, 1'b1});
        issue(f3(2'h2, 5'hf, 6'h38, 5'h1, {1'b0, 8'h80, 5'h2}), 64'h100, 64'h24);
        traps(7'h40);
        issue(f3(2'h2, 5'hf, 6'h38, 5'h1, {1'b1, 13'h0002}), 64'h100, 64'h0);
        traps(7'h01);
        proc_state_addr_mask = 1'b1;
        issue(f3(2'h2, 5'hf, 6'h38, 5'h1, {1'b1, 13'h0004}), 64'hffff_ffff_0000_0010, 64'h0);
        proc_state_addr_mask = 1'b0;
        chk("mask_target", jump_target, 64'h14);
        chk("mask_link", rd_value, 64'h9abc_def0);
    endtask
    // code = op3, size, signed
    function [8:0] ld_code(input [2:0] k);
        case (k)
            3'h0: ld_code = {6'h01, 3'h0};
            3'h1: ld_code = {6'h09, 3'h1};
            3'h2: ld_code = {6'h02, 3'h2};
            3'h3: ld_code = {6'h0a, 3'h3};
            3'h4: ld_code = {6'h00, 3'h4};
            3'h5: ld_code = {6'h08, 3'h5};
            default: ld_code = {6'h0b, 3'h6};
        endcase
    endfunction
    task t_load;
        reg     [8:0]  c;
        reg     [63:0] e;
        integer        k;
        for (k = 0; k < 7; k = k + 1) begin
            c = ld_code(k[2:0]);
            issue(f3(2'h3, 5'h4, c[8:3], 5'h1, {1'b1, 13'h0001}), 64'h1000, 64'h0);
            traps({6'h0, c[2:1] != 2'h0});
            issue(f3(2'h3, 5'h4, c[8:3], 5'h1, {1'b0, 8'h00, 5'h2}), 64'h2000, 64'h40);
            // extended loads leave the signed flag unspecified
            chk("load", {load_req, load_size, load_signed & (c[2:1] != 2'h3), load_addr[59:0]},
                {1'b1, c[2:0], 60'h2040});
            @(negedge sys_clk);
            mem_rdata = 64'h1234_5678_8080_8080;
            mem_rvalid = 1'b1;
            @(negedge sys_clk);
            mem_rvalid = 1'b0;
            case (c[2:1])
                2'h0: e = c[0] ? 64'hffff_ffff_ffff_ff80 : 64'h80;
                2'h1: e = c[0] ? 64'hffff_ffff_ffff_8080 : 64'h8080;
                2'h2: e = c[0] ? 64'hffff_ffff_8080_8080 : 64'h8080_8080;
                default: e = 64'h1234_5678_8080_8080;
            endcase
            chk("ld_result", load_result, e);
            chk("ld_done", {63'h0, load_done}, 64'h1);
        end
        issue(f3(2'h3, 5'h4, 6'h00, 5'h1, {1'b0, 8'h10, 5'h2}), 64'h0, 64'h0);
        traps(7'h40);
    endtask
    ////////////////////////////////////////////////////////////////
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // whole run is about a hundred cycles; this leaves ample margin
    initial begin
        #20000;
        err_count = err_count + 1;
        complete_run;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        t_fp;
        t_misc;
        t_jump;
        t_load;
        complete_run;
    end
endmodule // fjl_decode_tb
